// ==== hdl/eebac_pkg.sv ====
// Constants shared by the byte-wide nonvolatile access controller.
// Assumes one 50 MHz clock and an 8-bit register port.
package eebac_pkg;
   localparam int ADDR_W = 9;
   localparam int DATA_W = 8;
   localparam int NV_BYTES = 512;
   localparam logic [ADDR_W-1:0] NV_LAST = 9'h1ff;
   // Register offsets
   localparam logic [1:0] OFS_CTRL = 2'h0;
   localparam logic [1:0] OFS_DATA = 2'h1;
   localparam logic [1:0] OFS_ADRL = 2'h2;
   localparam logic [1:0] OFS_ADRH = 2'h3;
   // Control fields and data values
   localparam int BIT_READ = 0;
   localparam int BIT_PROG = 1;
   localparam int BIT_MASTER = 2;
   localparam int MODE_LSB = 4;
   localparam int MODE_MSB = 5;
   localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
   localparam logic [DATA_W-1:0] ERASED = 8'hff;
   // Timing in cycles, clock period in ns
   localparam logic [2:0] MASTER_WIN = 3'h4;
   localparam logic [2:0] READ_HALT = 3'h4;
   localparam logic [2:0] PROG_HALT = 3'h2;
   localparam int CLK_NS = 20;
   typedef enum logic [1:0] {
      EEBAC_ATOMIC = 2'h0,
      EEBAC_ERASE = 2'h1,
      EEBAC_WRITE = 2'h2,
      EEBAC_RSVD = 2'h3
   } eebac_mode_t;
endpackage

// ==== hdl/eebac_arr_if.sv ====
// Link between the access controller and its byte array.
// Assumes both ends share one clock.
`timescale 1ns/1ps
`default_nettype none
interface eebac_arr_if;
   logic rd;
   logic start;
   eebac_pkg::eebac_mode_t op;
   logic [eebac_pkg::ADDR_W-1:0] addr;
   logic [eebac_pkg::DATA_W-1:0] wdata;
   logic [eebac_pkg::DATA_W-1:0] rdata;
   logic busy;
   modport ctl(output rd, start, op, addr, wdata, input rdata, busy);
   modport arr(input rd, start, op, addr, wdata, output rdata, busy);
endinterface
`default_nettype wire

// ==== hdl/eebac_array.sv ====
// Nonvolatile byte array with self-timed erase and write.
// Assumes starts arrive only while idle.
`timescale 1ns/1ps
`default_nettype none
module eebac_array #(
   parameter int ATOMIC_CYCLES = 1000,
   parameter int SPLIT_CYCLES = 500
) (
   input wire logic ref_clk_in,
   input wire logic sys_rst_in,
   input wire logic ce_in,
   eebac_arr_if.arr port
);
   logic [eebac_pkg::DATA_W-1:0] mem [eebac_pkg::NV_BYTES];
   logic busy;
   logic next_busy;
   logic [15:0] cnt;
   logic [15:0] next_cnt;
   eebac_pkg::eebac_mode_t op_q;
   eebac_pkg::eebac_mode_t next_op;
   logic [eebac_pkg::ADDR_W-1:0] addr_q;
   logic [eebac_pkg::ADDR_W-1:0] next_addr;
   logic [eebac_pkg::DATA_W-1:0] data_q;
   logic [eebac_pkg::DATA_W-1:0] next_data;
   logic [eebac_pkg::DATA_W-1:0] rdata;
   logic [eebac_pkg::DATA_W-1:0] next_rdata;
   logic finish;

   assign port.busy = busy;
   assign port.rdata = rdata;

   always_comb begin
      next_busy = busy;
      next_cnt = cnt;
      next_op = op_q;
      next_addr = addr_q;
      next_data = data_q;
      next_rdata = rdata;
      finish = 1'b0;
      if (busy == 1'b1) begin
         // Reset does not abort a running operation
         next_cnt = cnt - 16'h0001;
         if (cnt == 16'h0001) begin
            next_busy = 1'b0;
            finish = 1'b1;
         end
      end else if (sys_rst_in) begin
         next_busy = 1'b0;
         next_cnt = 16'h0000;
         next_rdata = eebac_pkg::DATA_RST;
      end else if (port.start) begin
         next_busy = 1'b1;
         next_op = port.op;
         next_addr = port.addr;
         next_data = port.wdata;
         next_cnt = (port.op == eebac_pkg::EEBAC_ATOMIC) ? 16'(ATOMIC_CYCLES) : 16'(SPLIT_CYCLES);
      end else if (port.rd) begin
         next_rdata = mem[port.addr];
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (ce_in) begin
         busy <= next_busy;
         cnt <= next_cnt;
         op_q <= next_op;
         addr_q <= next_addr;
         data_q <= next_data;
         rdata <= next_rdata;
         if (finish) begin
            unique case (op_q)
               eebac_pkg::EEBAC_ATOMIC: mem[addr_q] <= data_q;
               eebac_pkg::EEBAC_ERASE: mem[addr_q] <= eebac_pkg::ERASED;
               eebac_pkg::EEBAC_WRITE: mem[addr_q] <= mem[addr_q] & data_q;
               default: mem[addr_q] <= mem[addr_q];
            endcase
         end
      end
   end

   AST_RESET_KEEPS_OP: assert property (@(posedge ref_clk_in)
      (ce_in && busy && sys_rst_in && cnt > 16'h0001) |=> busy)
      else $error("reset aborted a running operation");
endmodule
`default_nettype wire

// ==== hdl/eebac_top.sv ====
// Byte-wide nonvolatile access controller: registers, guard, stall.
// Assumes a core on the same clock driving one-cycle strobes.
`timescale 1ns/1ps
`default_nettype none
module eebac_top #(
   parameter int ATOMIC_CYCLES = 1000,
   parameter int SPLIT_CYCLES = 500
) (
   input wire logic ref_clk_in,
   input wire logic sys_rst_in,
   input wire logic ce_in,
   input wire logic [1:0] bus_addr_in,
   input wire logic [7:0] bus_wdata_in,
   input wire logic bus_we_in,
   input wire logic bus_re_in,
   output logic [7:0] bus_rdata_out,
   output logic cpu_halt_out,
   output logic prog_busy_out
);
   eebac_arr_if arr_if();

   eebac_array #(
      .ATOMIC_CYCLES(ATOMIC_CYCLES),
      .SPLIT_CYCLES(SPLIT_CYCLES)
   ) u_array (
      .ref_clk_in(ref_clk_in),
      .sys_rst_in(sys_rst_in),
      .ce_in(ce_in),
      .port(arr_if.arr)
   );

   function automatic logic hit(input logic strobe, input logic [1:0] adr, input logic [1:0] ofs);
      hit = strobe && (adr == ofs);
   endfunction

   logic [eebac_pkg::ADDR_W-1:0] nv_address_register;
   logic [eebac_pkg::ADDR_W-1:0] next_address;
   logic [7:0] nv_data_register;
   logic [7:0] next_data;
   eebac_pkg::eebac_mode_t program_mode_field;
   eebac_pkg::eebac_mode_t next_mode;
   logic [2:0] master_cnt;
   logic [2:0] next_master_cnt;
   logic [2:0] halt_cnt;
   logic [2:0] next_halt_cnt;
   logic read_pend;
   logic next_read_pend;
   logic [7:0] rdata;
   logic [7:0] next_rdata;
   logic [7:0] rd_mux;
   logic ctrl_wr;
   logic prog_req;
   logic start_go;
   logic read_go;
   logic master_set;
   logic busy;

   assign busy = arr_if.busy;
   assign ctrl_wr = hit(bus_we_in, bus_addr_in, eebac_pkg::OFS_CTRL);
   assign master_set = ctrl_wr && bus_wdata_in[eebac_pkg::BIT_MASTER] && !busy;
   assign prog_req = ctrl_wr && bus_wdata_in[eebac_pkg::BIT_PROG] && !busy;
   // Start needs an open master window and a defined mode
   assign start_go = prog_req && (master_cnt != 3'h0)
      && (next_mode != eebac_pkg::EEBAC_RSVD);
   assign read_go = ctrl_wr && bus_wdata_in[eebac_pkg::BIT_READ] && !busy && !prog_req;

   assign arr_if.start = ce_in && start_go;
   assign arr_if.rd = ce_in && read_go;
   assign arr_if.op = next_mode;
   assign arr_if.addr = nv_address_register;
   assign arr_if.wdata = nv_data_register;

   assign cpu_halt_out = (halt_cnt != 3'h0);
   assign prog_busy_out = busy;
   assign bus_rdata_out = rdata;

   always_comb begin
      rd_mux = 8'h00;
      unique case (bus_addr_in)
         eebac_pkg::OFS_CTRL: begin
            rd_mux[eebac_pkg::MODE_MSB:eebac_pkg::MODE_LSB] = program_mode_field;
            rd_mux[eebac_pkg::BIT_MASTER] = (master_cnt != 3'h0);
            rd_mux[eebac_pkg::BIT_PROG] = busy;
         end
         eebac_pkg::OFS_DATA: rd_mux = nv_data_register;
         eebac_pkg::OFS_ADRL: rd_mux = nv_address_register[7:0];
         eebac_pkg::OFS_ADRH: rd_mux[0] = nv_address_register[eebac_pkg::ADDR_W-1];
      endcase
   end

   always_comb begin
      next_address = nv_address_register;
      next_data = nv_data_register;
      next_mode = program_mode_field;
      next_master_cnt = master_cnt;
      next_halt_cnt = halt_cnt;
      next_read_pend = 1'b0;
      next_rdata = rdata;
      // Control writes cannot change the mode while busy; reset still loads atomic
      if (ctrl_wr && !busy) begin
         next_mode = eebac_pkg::eebac_mode_t'(bus_wdata_in[eebac_pkg::MODE_MSB:eebac_pkg::MODE_LSB]);
      end
      if (hit(bus_we_in, bus_addr_in, eebac_pkg::OFS_ADRL)) begin
         next_address[7:0] = bus_wdata_in;
      end
      if (hit(bus_we_in, bus_addr_in, eebac_pkg::OFS_ADRH)) begin
         next_address[eebac_pkg::ADDR_W-1] = bus_wdata_in[0];
      end
      if (hit(bus_we_in, bus_addr_in, eebac_pkg::OFS_DATA)) begin
         next_data = bus_wdata_in;
      end
      if (read_pend) begin
         next_data = arr_if.rdata;
      end
      // Master window counts down and self clears
      if (master_set) begin
         next_master_cnt = eebac_pkg::MASTER_WIN;
      end else if (master_cnt != 3'h0) begin
         next_master_cnt = master_cnt - 3'h1;
      end
      if (start_go) begin
         next_master_cnt = 3'h0;
         next_halt_cnt = eebac_pkg::PROG_HALT;
      end else if (read_go) begin
         next_halt_cnt = eebac_pkg::READ_HALT;
         next_read_pend = 1'b1;
      end else if (halt_cnt != 3'h0) begin
         next_halt_cnt = halt_cnt - 3'h1;
      end
      if (bus_re_in) begin
         next_rdata = rd_mux;
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (ce_in) begin
         nv_address_register <= next_address;
         if (sys_rst_in) begin
            nv_data_register <= eebac_pkg::DATA_RST;
            program_mode_field <= eebac_pkg::EEBAC_ATOMIC;
            master_cnt <= 3'h0;
            halt_cnt <= 3'h0;
            read_pend <= 1'b0;
            rdata <= 8'h00;
         end else begin
            nv_data_register <= next_data;
            program_mode_field <= next_mode;
            master_cnt <= next_master_cnt;
            halt_cnt <= next_halt_cnt;
            read_pend <= next_read_pend;
            rdata <= next_rdata;
         end
      end
   end

   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (sys_rst_in || !ce_in);

   AST_READ_HALT: assert property (read_go |=> cpu_halt_out [*4])
      else $error("read stall not four cycles");
   AST_PROG_HALT: assert property (start_go |=> cpu_halt_out [*2] ##1 !cpu_halt_out)
      else $error("program stall not two cycles");
   AST_START_WINDOW: assert property (arr_if.start |-> $past(master_set, 1) || $past(master_set, 2) || $past(master_set, 3) || $past(master_set, 4))
      else $error("start outside master window");
   AST_MODE_PASS: assert property (start_go |-> arr_if.op == eebac_pkg::eebac_mode_t'(bus_wdata_in[eebac_pkg::MODE_MSB:eebac_pkg::MODE_LSB]))
      else $error("wrong operation mode passed");
   AST_BUSY_SET: assert property (start_go |=> prog_busy_out)
      else $error("program bit not set after start");
   AST_NO_OVERLAP: assert property (busy |-> !arr_if.start && !arr_if.rd)
      else $error("access started while busy");
   AST_READ_DATA: assert property (read_go |=> ##1 nv_data_register == $past(arr_if.rdata))
      else $error("data register not loaded by read");
   AST_MASTER_CLR: assert property (master_set ##1 (!ctrl_wr) [*4] |-> master_cnt == 3'h1 ##1 master_cnt == 3'h0)
      else $error("master enable not cleared after four cycles");
   AST_RSVD_MODE: assert property (prog_req && bus_wdata_in[eebac_pkg::MODE_MSB:eebac_pkg::MODE_LSB] == 2'h3 |-> !arr_if.start)
      else $error("reserved mode started an operation");
   AST_REG_READ: assert property (bus_re_in |=> bus_rdata_out == $past(rd_mux))
      else $error("register read data wrong");

   COV_ATOMIC: cover property (start_go && next_mode == eebac_pkg::EEBAC_ATOMIC);
   COV_ERASE: cover property (start_go && next_mode == eebac_pkg::EEBAC_ERASE);
   COV_WRITE: cover property (start_go && next_mode == eebac_pkg::EEBAC_WRITE);
   COV_READ: cover property (read_go ##2 read_pend == 1'b0);
endmodule
`default_nettype wire

// ==== bench/eebac_core_model.sv ====
// Core model: one-cycle register strobes toward the controller.
// Assumes the controller samples on the rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module eebac_core_model (
   input wire logic clk_in,
   input wire logic [7:0] rdata_in,
   output logic [1:0] addr_out,
   output logic [7:0] wdata_out,
   output logic we_out,
   output logic re_out
);
   initial begin
      addr_out = 2'h0;
      wdata_out = 8'h00;
      we_out = 1'b0;
      re_out = 1'b0;
   end
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge clk_in);
      addr_out <= a;
      wdata_out <= d;
      we_out <= 1'b1;
      @(posedge clk_in);
      we_out <= 1'b0;
   endtask
   task automatic rd(input logic [1:0] a, output logic [7:0] d);
      @(posedge clk_in);
      addr_out <= a;
      re_out <= 1'b1;
      @(posedge clk_in);
      re_out <= 1'b0;
      #1 d = rdata_in;
   endtask
   // Address and data first, then master enable, then start
   task automatic prog(input logic [8:0] a, input logic [7:0] d, input logic [1:0] m, input int gap);
      wr(eebac_pkg::OFS_ADRL, a[7:0]);
      wr(eebac_pkg::OFS_ADRH, {7'h00, a[8]});
      wr(eebac_pkg::OFS_DATA, d);
      wr(eebac_pkg::OFS_CTRL, {2'h0, m, 4'h4});
      repeat (gap) @(posedge clk_in);
      wr(eebac_pkg::OFS_CTRL, {2'h0, m, 4'h2});
   endtask
endmodule
`default_nettype wire

// ==== bench/tb_top.sv ====
// Testbench: program, erase, read and refusal sequences.
// Assumes the core model drives the register port.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   localparam int AT = 12;
   localparam int SP = 6;
   logic ref_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic ce = 1'b1;
   logic [7:0] rdata, wdata, v;
   logic [1:0] addr;
   logic we, re, halt, busy;
   int miscompares = 0;
   int num_checks = 0;
   int busy_cnt = 0;
   int n;
   always #10 ref_clk = ~ref_clk;
   always @(posedge ref_clk) if (busy === 1'b1) busy_cnt <= busy_cnt + 1;
   eebac_top #(.ATOMIC_CYCLES(AT), .SPLIT_CYCLES(SP)) dut (.ref_clk_in(ref_clk), .sys_rst_in(sys_rst),
      .ce_in(ce), .bus_addr_in(addr), .bus_wdata_in(wdata), .bus_we_in(we), .bus_re_in(re),
      .bus_rdata_out(rdata), .cpu_halt_out(halt), .prog_busy_out(busy));
   eebac_core_model core (.clk_in(ref_clk), .rdata_in(rdata), .addr_out(addr), .wdata_out(wdata),
      .we_out(we), .re_out(re));
   task automatic chk(input logic [8:0] got, input logic [8:0] exp);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic halts(output int c);
      c = 0;
      #1;
      while (halt === 1'b1 && c < 20) begin
         c++;
         @(posedge ref_clk);
         #1;
      end
   endtask
   task automatic wait_idle();
      int k;
      k = 0;
      while (busy !== 1'b0 && k < 200) begin
         k++;
         @(posedge ref_clk);
         #1;
      end
      core.rd(eebac_pkg::OFS_CTRL, v);
      chk(v[1], 1'b0);
   endtask
   task automatic nv_read(input logic [8:0] a, input logic [7:0] e);
      int c;
      core.wr(eebac_pkg::OFS_ADRL, a[7:0]);
      core.wr(eebac_pkg::OFS_ADRH, {7'h00, a[8]});
      core.wr(eebac_pkg::OFS_CTRL, 8'h01);
      halts(c);
      chk(9'(c), 9'(eebac_pkg::READ_HALT));
      core.rd(eebac_pkg::OFS_DATA, v);
      chk(v, e);
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // Mode table: address, data, mode, gap, busy length, readback
   logic [8:0] ta [4] = '{9'h1ff, 9'h1ff, 9'h000, 9'h1ff};
   logic [7:0] td [4] = '{8'h00, 8'h5a, 8'h3c, 8'hc3};
   logic [7:0] te [4] = '{8'hff, 8'h5a, 8'h3c, 8'hc3};
   logic [1:0] tm [4] = '{2'h1, 2'h2, 2'h0, 2'h0};
   int tg [4] = '{0, 0, 1, 2};
   int tl [4] = '{SP, SP, AT, AT};
   initial begin
      #200000;
      miscompares++;
      print_verdict();
   end
   initial begin
      repeat (10) @(posedge ref_clk);
      sys_rst <= 1'b0;
      core.rd(eebac_pkg::OFS_CTRL, v);
      chk(v, 8'h00);
      core.rd(eebac_pkg::OFS_DATA, v);
      chk(v, eebac_pkg::DATA_RST);
      $display("reset test done");
      for (int i = 0; i < 4; i++) begin
         busy_cnt = 0;
         core.prog(ta[i], td[i], tm[i], tg[i]);
         halts(n);
         chk(9'(n), 9'(eebac_pkg::PROG_HALT));
         core.rd(eebac_pkg::OFS_CTRL, v);
         chk(v[1], 1'b1);
         wait_idle();
         chk(9'(busy_cnt), 9'(tl[i]));
         nv_read(ta[i], te[i]);
      end
      $display("mode test done");
      for (int i = 0; i < 2; i++) begin
         busy_cnt = 0;
         core.prog(9'h000, 8'h00, i == 0 ? 2'h0 : 2'h3, i == 0 ? 3 : 0);
         halts(n);
         chk(9'(n), 9'h000);
         repeat (AT) @(posedge ref_clk);
         chk(9'(busy_cnt), 9'h000);
         nv_read(9'h000, 8'h3c);
      end
      $display("guard test done");
      busy_cnt = 0;
      core.prog(9'h000, 8'h11, 2'h0, 0);
      halts(n);
      core.wr(eebac_pkg::OFS_CTRL, 8'h15);
      halts(n);
      chk(9'(n), 9'h000);
      core.rd(eebac_pkg::OFS_CTRL, v);
      chk(v, 8'h02);
      core.rd(eebac_pkg::OFS_DATA, v);
      chk(v, 8'h11);
      ce <= 1'b0;
      repeat (3) @(posedge ref_clk);
      ce <= 1'b1;
      wait_idle();
      chk(9'(busy_cnt), 9'(AT + 3));
      nv_read(9'h000, 8'h11);
      $display("busy test done");
      busy_cnt = 0;
      core.prog(9'h000, 8'h77, 2'h0, 0);
      halts(n);
      sys_rst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      sys_rst <= 1'b0;
      #1;
      chk(busy, 1'b1);
      core.rd(eebac_pkg::OFS_DATA, v);
      chk(v, eebac_pkg::DATA_RST);
      wait_idle();
      chk(9'(busy_cnt), 9'(AT));
      nv_read(9'h000, 8'h77);
      $display("reset during program test done");
      print_verdict();
   end
endmodule
`default_nettype wire
